// *** rtl/ssi_position_readout.sv ***
// ssi master for an absolute position encoder with apb registers and two filtered inputs
`include "ssi_position_readout_regs.svh"
`default_nettype none
module ssi_position_readout
  import ssi_position_readout_pkg::*;
#(
  parameter int unsigned Delay0p4Cycles = int'(`DLY_0P4_MS * `SYS_CLK_HZ / 1000.0),
  parameter int unsigned Delay0p8Cycles = int'(`DLY_0P8_MS * `SYS_CLK_HZ / 1000.0),
  parameter int unsigned Delay1p6Cycles = int'(`DLY_1P6_MS * `SYS_CLK_HZ / 1000.0),
  parameter int unsigned Delay3p2Cycles = int'(`DLY_3P2_MS * `SYS_CLK_HZ / 1000.0),
  parameter int unsigned Delay12p8Cycles = int'(`DLY_12P8_MS * `SYS_CLK_HZ / 1000.0),
  parameter int unsigned Delay20Cycles = int'(`DLY_20_MS * `SYS_CLK_HZ / 1000.0)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic serialClk,
  input wire logic encoderDataLine,
  input wire logic din0,
  input wire logic din1,
  output logic encoderFaultFlag,
  output logic input0LevelFlag,
  output logic input1LevelFlag,
  output logic [31:0] positionValue
);

  ////////////////////////////////////////////////////////////////////////////
  // timing counts derived from the clock rate

  localparam int unsigned Delay0p05Cycles = int'(`DLY_0P05_MS * `SYS_CLK_HZ / 1000.0);
  localparam int unsigned Delay0p1Cycles = int'(`DLY_0P1_MS * `SYS_CLK_HZ / 1000.0);
  localparam int unsigned ClkPerUs = `SYS_CLK_HZ / 1000000;
  localparam logic [10:0] Gap16Cycles = 11'(`GAP_16_US * ClkPerUs);
  localparam logic [10:0] Gap32Cycles = 11'(`GAP_32_US * ClkPerUs);
  localparam logic [10:0] Gap48Cycles = 11'(`GAP_48_US * ClkPerUs);
  localparam logic [10:0] Gap64Cycles = 11'(`GAP_64_US * ClkPerUs);

  typedef struct packed {
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic [1:0] fltLvl;
    logic [1:0][18:0] fltCnt;
    ssi_state_type st;
    logic [7:0] halfCnt;
    logic [10:0] gapCnt;
    logic [5:0] bitCnt;
    logic [40:0] shiftReg;
    logic sclk;
    logic enable;
    logic parityEn;
    logic dualCode;
    logic invertDir;
    logic isoMode;
    rate_type rate;
    gap_type gap;
    delay_type dly;
    logic [5:0] frameLen;
    logic [5:0] posLsb;
    logic [5:0] posMsb;
    logic fault;
    logic [31:0] position;
    logic [39:0] rawFrame;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_type;

  state_type q;
  state_type n;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // serial clock period in system clocks, rounded up so the rate is never exceeded
  function automatic logic [7:0] ratePeriod(input rate_type r);
    case (r)
      RATE_250K: ratePeriod = 8'((`SYS_CLK_HZ + `RATE_250K_HZ - 1) / `RATE_250K_HZ);
      RATE_500K: ratePeriod = 8'((`SYS_CLK_HZ + `RATE_500K_HZ - 1) / `RATE_500K_HZ);
      RATE_1M: ratePeriod = 8'((`SYS_CLK_HZ + `RATE_1M_HZ - 1) / `RATE_1M_HZ);
      RATE_1M5: ratePeriod = 8'((`SYS_CLK_HZ + `RATE_1M5_HZ - 1) / `RATE_1M5_HZ);
      RATE_2M: ratePeriod = 8'((`SYS_CLK_HZ + `RATE_2M_HZ - 1) / `RATE_2M_HZ);
      default: ratePeriod = 8'((`SYS_CLK_HZ + `RATE_125K_HZ - 1) / `RATE_125K_HZ);
    endcase
  endfunction

  // filter length per delay code; none means the synchronised level passes at once
  function automatic logic [18:0] delayCycles(input delay_type d);
    case (d)
      DLY_0P05: delayCycles = 19'(Delay0p05Cycles);
      DLY_0P1: delayCycles = 19'(Delay0p1Cycles);
      DLY_0P4: delayCycles = 19'(Delay0p4Cycles);
      DLY_0P8: delayCycles = 19'(Delay0p8Cycles);
      DLY_1P6: delayCycles = 19'(Delay1p6Cycles);
      DLY_3P2: delayCycles = 19'(Delay3p2Cycles);
      DLY_12P8: delayCycles = 19'(Delay12p8Cycles);
      DLY_20: delayCycles = 19'(Delay20Cycles);
      default: delayCycles = 19'h1;
    endcase
  endfunction

  // frame layout check applied to writes of the frame register
  function automatic logic frameLegal(input logic [5:0] len, input logic [5:0] lsb, input logic [5:0] msb);
    frameLegal = (len >= `FRAME_LEN_MIN) && (len <= `FRAME_LEN_MAX) // see R1
      && (lsb < msb) // see R13
      && (msb < len) // see R14
      && ((msb - lsb) < `POS_SPAN_LIMIT); // see R15
  endfunction

  // gray to binary over a zero-extended field; leading zeros leave it exact
  function automatic logic [31:0] grayToBin(input logic [31:0] g);
    logic [31:0] b;
    b = '0;
    b[31] = g[31];
    for (int i = 30; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    grayToBin = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [5:0] nBits;
  logic [7:0] period;
  logic [7:0] lowHalf;
  logic [7:0] highHalf;
  logic gapDone;
  logic [39:0] frame;
  logic [31:0] mask;
  logic [31:0] field;
  logic [5:0] span;
  logic [18:0] dlyLen;
  logic ctrlOk;
  logic frameOk;

  always_comb begin
    n = q;
    // pins from outside the clock domain pass two flip-flops first
    n.syncA = {din1, din0, encoderDataLine};
    n.syncB = q.syncA;

    // one delay setting serves both inputs
    dlyLen = delayCycles(q.dly); // see R19, R18
    for (int i = 0; i < 2; i++) begin
      if (q.syncB[i + 1] != q.fltLvl[i]) begin
        if (q.fltCnt[i] >= dlyLen - 19'h1) begin
          n.fltLvl[i] = q.syncB[i + 1]; // see R16
          n.fltCnt[i] = '0;
        end else begin
          n.fltCnt[i] = q.fltCnt[i] + 19'h1;
        end
      end else begin
        n.fltCnt[i] = '0; // a short pulse restarts the count, see R17
      end
    end

    // apb: answer registered in the setup cycle, commit in the access cycle
    ctrlOk = (pwdata[`CTRL_RATE_LSB +: 3] <= 3'(RATE_2M))
      && (pwdata[`CTRL_GAP_LSB +: 3] <= 3'(GAP_64US))
      && (pwdata[`CTRL_DELAY_LSB +: 4] <= 4'(DLY_20));
    frameOk = frameLegal(pwdata[`FRAME_LEN_LSB +: 6], pwdata[`FRAME_POSLSB_LSB +: 6],
      pwdata[`FRAME_POSMSB_LSB +: 6]);
    n.pready = 1'b0;
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = '0;
      case (paddr)
        `REG_CTRL_OFS: begin
          n.prdata[`CTRL_EN_BIT] = q.enable;
          n.prdata[`CTRL_PARITY_BIT] = q.parityEn;
          n.prdata[`CTRL_DUAL_BIT] = q.dualCode;
          n.prdata[`CTRL_INVERT_BIT] = q.invertDir;
          n.prdata[`CTRL_ISO_BIT] = q.isoMode;
          n.prdata[`CTRL_RATE_LSB +: 3] = q.rate;
          n.prdata[`CTRL_GAP_LSB +: 3] = q.gap;
          n.prdata[`CTRL_DELAY_LSB +: 4] = q.dly;
          n.pslverr = pwrite && !ctrlOk;
        end
        `REG_FRAME_OFS: begin
          n.prdata[`FRAME_LEN_LSB +: 6] = q.frameLen;
          n.prdata[`FRAME_POSLSB_LSB +: 6] = q.posLsb;
          n.prdata[`FRAME_POSMSB_LSB +: 6] = q.posMsb;
          n.pslverr = pwrite && !frameOk;
        end
        `REG_STATUS_OFS: begin
          n.prdata[3:0] = {q.st != SSI_IDLE, q.fltLvl[1], q.fltLvl[0], q.fault};
        end
        `REG_POSITION_OFS: n.prdata = q.position;
        `REG_RAW_LO_OFS: n.prdata = q.rawFrame[31:0];
        `REG_RAW_HI_OFS: n.prdata[7:0] = q.rawFrame[39:32];
        default: n.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && q.pready && pwrite && !q.pslverr) begin
      case (paddr)
        `REG_CTRL_OFS: begin
          n.enable = pwdata[`CTRL_EN_BIT];
          n.parityEn = pwdata[`CTRL_PARITY_BIT];
          n.dualCode = pwdata[`CTRL_DUAL_BIT];
          n.invertDir = pwdata[`CTRL_INVERT_BIT];
          n.isoMode = pwdata[`CTRL_ISO_BIT];
          n.rate = rate_type'(pwdata[`CTRL_RATE_LSB +: 3]);
          n.gap = gap_type'(pwdata[`CTRL_GAP_LSB +: 3]);
          n.dly = delay_type'(pwdata[`CTRL_DELAY_LSB +: 4]);
        end
        `REG_FRAME_OFS: begin
          n.frameLen = pwdata[`FRAME_LEN_LSB +: 6];
          n.posLsb = pwdata[`FRAME_POSLSB_LSB +: 6];
          n.posMsb = pwdata[`FRAME_POSMSB_LSB +: 6];
        end
        `REG_STATUS_OFS: begin
          if (pwdata[`STATUS_FAULT_BIT]) begin
            n.fault = 1'b0; // a parity error in the same cycle still wins below
          end
        end
        default: begin
        end
      endcase
    end

    // serial link timing
    nBits = q.frameLen + {5'h0, q.parityEn}; // parity rides on top of the length, see R2, R3
    period = ratePeriod(q.rate); // see R8
    lowHalf = period >> 1;
    highHalf = period - lowHalf;
    // automatic gap outside iso mode waits for the encoder to release its data line, capped at 64 us
    case (q.gap)
      GAP_16US: gapDone = q.gapCnt >= Gap16Cycles; // see R9
      GAP_32US: gapDone = q.gapCnt >= Gap32Cycles;
      GAP_48US: gapDone = q.gapCnt >= Gap48Cycles;
      GAP_64US: gapDone = q.gapCnt >= Gap64Cycles;
      default: begin
        if (q.isoMode) begin
          gapDone = q.gapCnt >= Gap64Cycles; // see R12
        end else begin
          gapDone = (q.gapCnt >= {3'h0, period} && q.syncB[0]) || q.gapCnt >= Gap64Cycles; // see R11
        end
      end
    endcase

    // result extraction from the finished frame
    frame = q.parityEn ? q.shiftReg[40:1] : q.shiftReg[39:0];
    span = q.posMsb - q.posLsb;
    mask = 32'((33'h2 << span) - 33'h1);
    field = 32'(frame >> q.posLsb) & mask;
    if (!q.dualCode) begin
      field = grayToBin(field); // only the masked field is touched, see R5, R6
    end
    if (q.invertDir) begin
      field = field ^ mask; // see R7
    end

    // frame sequencer; serial clock idles high
    case (q.st)
      SSI_IDLE: begin
        n.sclk = 1'b1;
        if (q.gapCnt != 11'h7ff) begin
          n.gapCnt = q.gapCnt + 11'h1;
        end
        if (q.enable && gapDone) begin
          n.st = SSI_LOW;
          n.sclk = 1'b0;
          n.halfCnt = '0;
          n.bitCnt = '0;
          n.shiftReg = '0;
        end
      end
      SSI_LOW: begin
        n.halfCnt = q.halfCnt + 8'h1;
        if (q.halfCnt >= lowHalf - 8'h1) begin
          n.halfCnt = '0;
          if (q.bitCnt != 6'h0) begin
            n.shiftReg = {q.shiftReg[39:0], q.syncB[0]}; // msb first, see R20
          end
          if (q.bitCnt == nBits) begin
            n.st = SSI_DONE;
            n.sclk = 1'b1;
          end else begin
            n.st = SSI_HIGH;
            n.sclk = 1'b1;
          end
        end
      end
      SSI_HIGH: begin
        n.halfCnt = q.halfCnt + 8'h1;
        if (q.halfCnt >= highHalf - 8'h1) begin
          n.halfCnt = '0;
          n.bitCnt = q.bitCnt + 6'h1;
          n.st = SSI_LOW;
          n.sclk = 1'b0;
        end
      end
      SSI_DONE: begin
        n.st = SSI_IDLE;
        n.gapCnt = '0;
        // unreceived high bits are zero, so the xor covers just the frame
        if (q.parityEn && (^q.shiftReg)) begin
          n.fault = 1'b1; // see R4, R21
        end else begin
          n.rawFrame = frame;
          n.position = field; // see R21
        end
      end
      default: n.st = SSI_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{
        syncA: 3'h0, syncB: 3'h0, fltLvl: 2'h0, fltCnt: '0, st: SSI_IDLE,
        halfCnt: 8'h0, gapCnt: 11'h0, bitCnt: 6'h0, shiftReg: 41'h0, sclk: 1'b1,
        enable: 1'b0, parityEn: 1'b0, dualCode: 1'b0, invertDir: 1'b0, isoMode: 1'b0,
        rate: RATE_125K, gap: GAP_AUTO, dly: DLY_0P1,
        frameLen: `FRAME_LEN_RST, posLsb: `POS_LSB_RST, posMsb: `POS_MSB_RST,
        fault: 1'b0, position: 32'h0, rawFrame: 40'h0,
        prdata: 32'h0, pready: 1'b0, pslverr: 1'b0
      };
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign serialClk = q.sclk;
  assign encoderFaultFlag = q.fault;
  assign input0LevelFlag = q.fltLvl[0];
  assign input1LevelFlag = q.fltLvl[1];
  assign positionValue = q.position;

endmodule
`default_nettype wire

// *** shared/ssi_position_readout_regs.svh ***
// register map, field positions, reset values and timing constants of the position readout
// Summary of operation
// R1: frame length 10 to 40 bits, default 13
// R2: parity bit not counted in frame length
// R3: parity enabled clocks one extra parity bit
// R4: parity mismatch sets encoder fault flag
// R5: gray code converted to binary, dual passes
// R6: gray conversion only between LSB and MSB
// R7: direction inversion only on position field
// R8: serial clock rate selectable, 125 kHz default
// R9: idle gap auto or 16..64 us
// R10: encoder monoflop must fit configured gap
// R11: automatic gap adapts to connected encoder
// R12: isochronous automatic gap is 64 us
// R13: position LSB number default 0, below MSB
// R14: MSB default 12, below frame length
// R15: MSB minus LSB must stay under 32
// R16: unused inputs only report filtered level
// R17: pulses shorter than input delay are suppressed
// R18: input delay none up to 20 ms
// R19: one delay setting shared by all inputs
// R20: frame shifted in MSB first, bit per period
// R21: even parity; position updated only on pass
`ifndef SSI_POSITION_READOUT_REGS_SVH
`define SSI_POSITION_READOUT_REGS_SVH

`define REG_CTRL_OFS 8'h00
`define REG_FRAME_OFS 8'h04
`define REG_STATUS_OFS 8'h08
`define REG_POSITION_OFS 8'h0c
`define REG_RAW_LO_OFS 8'h10
`define REG_RAW_HI_OFS 8'h14

`define CTRL_EN_BIT 0
`define CTRL_PARITY_BIT 1
`define CTRL_DUAL_BIT 2
`define CTRL_INVERT_BIT 3
`define CTRL_ISO_BIT 4
`define CTRL_RATE_LSB 8
`define CTRL_GAP_LSB 12
`define CTRL_DELAY_LSB 16
`define FRAME_LEN_LSB 0
`define FRAME_POSLSB_LSB 8
`define FRAME_POSMSB_LSB 16
`define STATUS_FAULT_BIT 0

`define FRAME_LEN_RST 6'd13
`define FRAME_LEN_MIN 6'd10
`define FRAME_LEN_MAX 6'd40
`define POS_LSB_RST 6'd0
`define POS_MSB_RST 6'd12
`define POS_SPAN_LIMIT 6'd32

`define SYS_CLK_HZ 25000000
`define RATE_125K_HZ 125000
`define RATE_250K_HZ 250000
`define RATE_500K_HZ 500000
`define RATE_1M_HZ 1000000
`define RATE_1M5_HZ 1500000
`define RATE_2M_HZ 2000000
`define GAP_16_US 16
`define GAP_32_US 32
`define GAP_48_US 48
`define GAP_64_US 64
`define DLY_0P05_MS 0.05
`define DLY_0P1_MS 0.1
`define DLY_0P4_MS 0.4
`define DLY_0P8_MS 0.8
`define DLY_1P6_MS 1.6
`define DLY_3P2_MS 3.2
`define DLY_12P8_MS 12.8
`define DLY_20_MS 20.0

`endif

// *** shared/ssi_position_readout_pkg.sv ***
// types shared by the position readout design and its bench
`default_nettype none
package ssi_position_readout_pkg;

  typedef enum logic [2:0] {
    RATE_125K = 3'h0,
    RATE_250K = 3'h1,
    RATE_500K = 3'h2,
    RATE_1M = 3'h3,
    RATE_1M5 = 3'h4,
    RATE_2M = 3'h5
  } rate_type;

  typedef enum logic [2:0] {
    GAP_AUTO = 3'h0,
    GAP_16US = 3'h1,
    GAP_32US = 3'h2,
    GAP_48US = 3'h3,
    GAP_64US = 3'h4
  } gap_type;

  typedef enum logic [3:0] {
    DLY_NONE = 4'h0,
    DLY_0P05 = 4'h1,
    DLY_0P1 = 4'h2,
    DLY_0P4 = 4'h3,
    DLY_0P8 = 4'h4,
    DLY_1P6 = 4'h5,
    DLY_3P2 = 4'h6,
    DLY_12P8 = 4'h7,
    DLY_20 = 4'h8
  } delay_type;

  typedef enum logic [1:0] {
    SSI_IDLE = 2'h0,
    SSI_LOW = 2'h1,
    SSI_HIGH = 2'h2,
    SSI_DONE = 2'h3
  } ssi_state_type;

endpackage
`default_nettype wire

// *** tb/ssi_encoder_model.sv ***
// behavioural absolute encoder that shifts a frame out on the serial clock
`default_nettype none
module ssi_encoder_model (
  input wire logic serialClk,
  input wire logic [40:0] frameWord,
  input wire logic [5:0] bitCount,
  output logic encoderDataLine
);
  timeunit 1ns;
  timeprecision 1ns;
  int idx = 0;
  logic inFrame = 1'b0;
  initial encoderDataLine = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // first fall after idle latches the bit count; a frame in progress ignores falls
  always @(negedge serialClk) begin
    if (!inFrame) begin
      inFrame <= 1'b1;
      idx <= bitCount;
    end
  end
  // new bit on each rise, msb first; released line sits high as the ready level
  always @(posedge serialClk) begin
    if (inFrame && idx > 0) begin
      encoderDataLine <= frameWord[idx-1];
      idx <= idx - 1;
    end else if (inFrame) begin
      inFrame <= 1'b0;
      encoderDataLine <= 1'b1; // monoflop ends at once, inside any gap
    end
  end
endmodule
`default_nettype wire

// *** tb/ssi_position_readout_sva.sv ***
// port checker for the position readout, bound to the top module
`default_nettype none
module ssi_position_readout_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serialClk,
  input wire logic din0,
  input wire logic din1,
  input wire logic encoderFaultFlag,
  input wire logic input0LevelFlag,
  input wire logic input1LevelFlag,
  input wire logic [31:0] positionValue
);
  logic clrWrite_q;
  // registered clear request so a flag fall can be tied to its cause
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) clrWrite_q <= 1'b0;
    else clrWrite_q <= psel && penable && pwrite && paddr == 8'h08 && pwdata[0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_onecyc; pready |=> !pready; endproperty
  a_onecyc: assert property (p_onecyc) else $error("ready held too long");
  property p_unmapped; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("refused read not zero");
  property p_shortlen; psel && penable && pwrite && paddr == 8'h04 && pwdata[5:0] < 6'd10 |-> pslverr; endproperty
  a_shortlen: assert property (p_shortlen) else $error("short frame length taken");
  property p_lowhalf; $fell(serialClk) |-> !serialClk [*6]; endproperty
  a_lowhalf: assert property (p_lowhalf) else $error("serial low half too short");
  property p_highhalf; $rose(serialClk) |-> serialClk [*6]; endproperty
  a_highhalf: assert property (p_highhalf) else $error("serial high half too short");
  property p_posidle; !$stable(positionValue) |-> serialClk; endproperty
  a_posidle: assert property (p_posidle) else $error("position moved inside frame");
  property p_badkeep; $rose(encoderFaultFlag) |-> serialClk && $stable(positionValue); endproperty
  a_badkeep: assert property (p_badkeep) else $error("bad frame touched position");
  property p_faultclr; $fell(encoderFaultFlag) |-> clrWrite_q; endproperty
  a_faultclr: assert property (p_faultclr) else $error("fault cleared without write");
  property p_in0; $rose(input0LevelFlag) |-> $past(din0, 3); endproperty
  a_in0: assert property (p_in0) else $error("input 0 rose without pin");
  property p_in1; $fell(input1LevelFlag) |-> !$past(din1, 3); endproperty
  a_in1: assert property (p_in1) else $error("input 1 fell without pin");
endmodule
bind ssi_position_readout ssi_position_readout_sva ssi_position_readout_sva_i (.clk, .arst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serialClk, .din0, .din1, .encoderFaultFlag,
  .input0LevelFlag, .input1LevelFlag, .positionValue);
`default_nettype wire

// *** tb/tb_ssi_position_readout.sv ***
// register level bench for the position readout with an encoder model
`default_nettype none
module tb_ssi_position_readout;
  import ssi_position_readout_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, din0 = 1'b0, din1 = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, positionValue, rd;
  logic pready, pslverr, serialClk, encoderDataLine, encoderFaultFlag, input0LevelFlag, input1LevelFlag, err;
  logic [40:0] frameWord = 41'h0;
  logic [5:0] bitCount = 6'd13;
  logic [23:0] fr;
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  time lastRise = 0;
  ssi_position_readout #(.Delay0p4Cycles(20), .Delay0p8Cycles(30), .Delay1p6Cycles(40), .Delay3p2Cycles(50),
    .Delay12p8Cycles(60)) ssi_position_readout_i (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialClk(serialClk), .encoderDataLine(encoderDataLine), .din0(din0), .din1(din1),
    .encoderFaultFlag(encoderFaultFlag), .input0LevelFlag(input0LevelFlag), .input1LevelFlag(input1LevelFlag),
    .positionValue(positionValue));
  ssi_encoder_model ssi_encoder_model_i (.serialClk(serialClk), .frameWord(frameWord), .bitCount(bitCount),
    .encoderDataLine(encoderDataLine));
  ////////////////////////////////////////////////////////////////////////
  // clock, watchdog and rise timestamp
  initial forever #20 clk = ~clk;
  always @(posedge serialClk) lastRise = $time;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; a free cycle first keeps back to back calls clean
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] mk(input logic [4:0] fl, input logic [2:0] rt, input logic [2:0] gp,
                                     input logic [3:0] dl);
    return {12'h0, dl, 1'b0, gp, 1'b0, rt, 3'h0, fl};
  endfunction
  // long high stretch marks the end of a frame, shorter than any fixed gap
  task automatic frame_done(input int lim);
    int hi;
    hi = 0;
    while (hi < lim) begin
      @(posedge clk);
      hi = serialClk ? hi + 1 : 0;
    end
  endtask
  // one frame with the given control word, then stop before the next
  task automatic one_frame(input logic [31:0] c);
    apb(1'b1, 8'h00, c);
    @(negedge serialClk);
    frame_done(150);
    apb(1'b1, 8'h00, mk(5'h0, 3'h5, 3'h4, 4'h2));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] fv[6] = '{32'h000c0009, 32'h000c0029, 32'h0005050d, 32'h000d000d, 32'h0009000a, 32'h00270828};
    int pv[6] = '{200, 100, 50, 25, 17, 13};
    int gv[6] = '{400, 800, 1200, 1600, 1600, 15};
    int g;
    time t1;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00020000);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h000c000d);
    chk(positionValue, 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h04, fv[i]);
      chk(err, i < 4);
    end
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, fv[5]);
    apb(1'b1, 8'h00, mk(5'h1, 3'h6, 3'h0, 4'h2));
    chk(err, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test registers done");
    // model frame must match the 40 bit layout left behind, or it drifts out of step
    bitCount = 6'd40;
    for (int r = 0; r < 6; r++) begin
      apb(1'b1, 8'h00, mk(5'h1, r[2:0], 3'h4, 4'h2));
      @(negedge serialClk);
      @(posedge serialClk);
      t1 = $time;
      @(posedge serialClk);
      chk(($time - t1) / 40, pv[r]);
      frame_done(150);
      apb(1'b1, 8'h00, mk(5'h0, 3'h5, 3'h4, 4'h2));
    end
    $display("test rates done");
    // last pass is automatic outside iso: one period plus released data line
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h00, mk(i == 4 ? 5'h11 : 5'h1, 3'h5, i >= 4 ? 3'h0 : 3'(i + 1), 4'h2));
      @(negedge serialClk);
      frame_done(10);
      @(negedge serialClk);
      g = ($time - lastRise) / 40;
      chk(g >= gv[i] && g <= gv[i] + 3, 1);
      frame_done(10);
      apb(1'b1, 8'h00, mk(5'h0, 3'h5, 3'h4, 4'h2));
    end
    $display("test gaps done");
    apb(1'b1, 8'h04, 32'h000c000d);
    bitCount = 6'd13;
    frameWord = {28'h0, 13'h1a5b ^ (13'h1a5b >> 1)};
    one_frame(mk(5'h1, 3'h5, 3'h4, 4'h2));
    chk(positionValue, 32'h1a5b);
    apb(1'b1, 8'h04, 32'h00140418);
    bitCount = 6'd24;
    frameWord = {17'h0, 3'b101, 17'h1b3c5 ^ (17'h1b3c5 >> 1), 4'b0110};
    one_frame(mk(5'h1, 3'h5, 3'h4, 4'h2));
    chk(positionValue, 32'h1b3c5);
    fr = {3'b011, 17'h0a5a5, 4'b1001};
    bitCount = 6'd25;
    frameWord = {16'h0, fr, ^fr};
    one_frame(mk(5'hf, 3'h5, 3'h4, 4'h2));
    chk(positionValue, {15'h0, ~17'h0a5a5});
    chk(encoderFaultFlag, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, {8'h0, fr});
    fr = {3'b011, 17'h13333, 4'b1001};
    frameWord = {16'h0, fr, ~^fr};
    one_frame(mk(5'hf, 3'h5, 3'h4, 4'h2));
    chk(encoderFaultFlag, 1'b1);
    chk(positionValue, {15'h0, ~17'h0a5a5});
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[0], 1'b0);
    $display("test frames done");
    apb(1'b1, 8'h00, mk(5'h0, 3'h5, 3'h4, 4'h3));
    din0 <= 1'b1;
    din1 <= 1'b1;
    repeat (10) @(posedge clk);
    din0 <= 1'b0;
    din1 <= 1'b0;
    repeat (40) @(posedge clk);
    chk({input1LevelFlag, input0LevelFlag}, 2'b00);
    din0 <= 1'b1;
    repeat (40) @(posedge clk);
    chk({input1LevelFlag, input0LevelFlag}, 2'b01);
    din1 <= 1'b1;
    repeat (40) @(posedge clk);
    chk({input1LevelFlag, input0LevelFlag}, 2'b11);
    din1 <= 1'b0;
    repeat (40) @(posedge clk);
    chk({input1LevelFlag, input0LevelFlag}, 2'b01);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[2:1], 2'b01);
    $display("test inputs done");
    print_verdict();
  end
endmodule
`default_nettype wire
